// ==== pursq_params.svh ====
`ifndef PURSQ_PARAMS_SVH
`define PURSQ_PARAMS_SVH

// Power-up timer length and its RC oscillator rate
`define PURSQ_POWER_UP_MS 96
`define PURSQ_RC_OSC_KHZ 250

// Oscillator start-up length in main oscillator cycles
`define PURSQ_STARTUP_CYCLES 1024

// Oscillator mode codes that need a start-up delay on wake
`define PURSQ_MODE_LOW_FREQ 2'h0
`define PURSQ_MODE_CRYSTAL 2'h1

// Bit positions in the synchroniser vector
`define PURSQ_SY_RC 0
`define PURSQ_SY_OSC 1
`define PURSQ_SY_POR 2
`define PURSQ_SY_PIN 3
`define PURSQ_SY_LVL 4
`define PURSQ_SY_TIED 5
`define PURSQ_SY_W 6

`endif

// ==== pursq_pkg.sv ====
package pursq_pkg;

  typedef enum logic [1:0] {
    PURSQ_HOLD,
    PURSQ_POWER_UP,
    PURSQ_RUN,
    PURSQ_WAKE
  } pursq_state_type;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic rc_prev;
    logic osc_prev;
    logic rel_prev;
    pursq_state_type state;
    logic core_rst_n;
    logic wake_hold;
    logic pu_start;
    logic su_start;
    logic abort;
  } pursq_top_state_type;

endpackage : pursq_pkg

// ==== pursq_edge_counter.sv ====
`timescale 1ns/1ps
`include "pursq_params.svh"

module pursq_edge_counter
  import pursq_pkg::*;
#(
  parameter int COUNT = `PURSQ_STARTUP_CYCLES,
  parameter int WIDTH = $clog2(COUNT + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic gate,
  // Status
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic busy;
    logic done;
  } pursq_cnt_state_type;

  localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT - 1);

  pursq_cnt_state_type st_ff;
  pursq_cnt_state_type nxt_st;

  // Count gated ticks from start until the last one
  always_comb begin
    nxt_st = st_ff;
    if (abort) begin
      nxt_st.count = '0;
      nxt_st.busy = 1'h0;
      nxt_st.done = 1'h0;
    end else if (start) begin
      nxt_st.count = '0;
      nxt_st.busy = 1'h1;
      nxt_st.done = 1'h0;
    end else if (st_ff.busy && tick && gate) begin
      if (st_ff.count == LAST) begin
        nxt_st.busy = 1'h0;
        nxt_st.done = 1'h1;
      end else begin
        nxt_st.count = st_ff.count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_done_after_last:
    assert property ($rose(st_ff.done) |-> $past(st_ff.count) == LAST && $past(st_ff.busy))
    else $error("done rose before the last tick");

  a_done_needs_tick:
    assert property ($rose(st_ff.done) |-> $past(tick) && $past(gate) && !$past(abort))
    else $error("done rose without a gated tick");

endmodule : pursq_edge_counter

// ==== pursq_top.sv ====
// Overview of operation
// - Hold core reset while supply below trip
// - Reset on supply rising and falling through trip
// - Power-up timer gives one 96 ms time-out
// - Tied pin: timer starts on supply detect rise
// - Separate pin: timer starts when pin seen high
// - Core held in reset while timer runs
// - Power-up timer counts RC oscillator ticks only
// - Every timer start also runs 1024-cycle start-up
// - Wake runs start-up only in crystal, low-frequency
// - Timer and start-up counter run together
// - Start-up counter counts main oscillator pulses
// - Start-up counts only above threshold; gates release
`timescale 1ns/1ps
`include "pursq_params.svh"

module pursq_top
  import pursq_pkg::*;
#(
  parameter int RC_OSC_KHZ = `PURSQ_RC_OSC_KHZ,
  parameter int POWER_UP_TICKS = `PURSQ_POWER_UP_MS * RC_OSC_KHZ,
  parameter int STARTUP_CYCLES = `PURSQ_STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Asynchronous analog and pin inputs
  input wire logic POR_DETECT,
  input wire logic MASTER_RESET_PIN,
  input wire logic MRST_TIED,
  input wire logic RC_OSC_IN,
  input wire logic MAIN_OSC_IN,
  input wire logic OSC_LEVEL_OK,
  // Same-domain controls
  input wire logic [1:0] OSC_MODE,
  input wire logic WAKE_REQ,
  // Status
  output logic CORE_RESET_N,
  output logic WAKE_HOLD,
  output logic POWER_UP_TIMER_BUSY,
  output logic OSC_STARTUP_BUSY
);

  localparam pursq_top_state_type RESET_ST = '{
    sync1: 6'h00,
    sync2: 6'h00,
    rc_prev: 1'h0,
    osc_prev: 1'h0,
    rel_prev: 1'h0,
    state: PURSQ_HOLD,
    core_rst_n: 1'h0,
    wake_hold: 1'h0,
    pu_start: 1'h0,
    su_start: 1'h0,
    abort: 1'h0
  };

  // Modes that need the oscillator start-up delay
  function automatic logic slow_start(input logic [1:0] mode);
    slow_start = (mode == `PURSQ_MODE_LOW_FREQ) || (mode == `PURSQ_MODE_CRYSTAL);
  endfunction : slow_start

  logic rst_meta_ff;
  logic rst_sync_ff;
  pursq_top_state_type st_ff;
  pursq_top_state_type nxt_st;
  logic [`PURSQ_SY_W-1:0] raw_in;
  logic rc_tick;
  logic osc_tick;
  logic release_lvl;
  logic release_rise;
  logic pu_done;
  logic su_done;
  logic pu_busy;
  logic su_busy;

  // Reset release through two flip-flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'h0;
      rst_sync_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign raw_in[`PURSQ_SY_RC] = RC_OSC_IN;
  assign raw_in[`PURSQ_SY_OSC] = MAIN_OSC_IN;
  assign raw_in[`PURSQ_SY_POR] = POR_DETECT;
  assign raw_in[`PURSQ_SY_PIN] = MASTER_RESET_PIN;
  assign raw_in[`PURSQ_SY_LVL] = OSC_LEVEL_OK;
  assign raw_in[`PURSQ_SY_TIED] = MRST_TIED;

  // Tick and release detection on synchronised copies
  assign rc_tick = st_ff.sync2[`PURSQ_SY_RC] && !st_ff.rc_prev;
  assign osc_tick = st_ff.sync2[`PURSQ_SY_OSC] && !st_ff.osc_prev;
  assign release_lvl = st_ff.sync2[`PURSQ_SY_POR] &&
                       (st_ff.sync2[`PURSQ_SY_TIED] || st_ff.sync2[`PURSQ_SY_PIN]);
  assign release_rise = release_lvl && !st_ff.rel_prev;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = raw_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.rc_prev = st_ff.sync2[`PURSQ_SY_RC];
    nxt_st.osc_prev = st_ff.sync2[`PURSQ_SY_OSC];
    nxt_st.rel_prev = release_lvl;
    nxt_st.pu_start = 1'h0;
    nxt_st.su_start = 1'h0;
    nxt_st.abort = 1'h0;
    if (!release_lvl) begin
      // Supply below trip or untied pin low: reset now, drop any timing
      nxt_st.state = PURSQ_HOLD;
      nxt_st.core_rst_n = 1'h0;
      nxt_st.wake_hold = 1'h0;
      nxt_st.abort = 1'h1;
    end else begin
      case (st_ff.state)
        PURSQ_HOLD: begin
          nxt_st.core_rst_n = 1'h0;
          if (release_rise) begin
            nxt_st.pu_start = 1'h1;
            nxt_st.su_start = 1'h1;
            nxt_st.state = PURSQ_POWER_UP;
          end
        end
        PURSQ_POWER_UP: begin
          nxt_st.core_rst_n = 1'h0;
          if (pu_done && su_done && !st_ff.pu_start && !st_ff.su_start) begin
            nxt_st.core_rst_n = 1'h1;
            nxt_st.state = PURSQ_RUN;
          end
        end
        PURSQ_RUN: begin
          nxt_st.core_rst_n = 1'h1;
          if (WAKE_REQ && slow_start(OSC_MODE)) begin
            nxt_st.su_start = 1'h1;
            nxt_st.wake_hold = 1'h1;
            nxt_st.state = PURSQ_WAKE;
          end
        end
        PURSQ_WAKE: begin
          if (su_done && !st_ff.su_start) begin
            nxt_st.wake_hold = 1'h0;
            nxt_st.state = PURSQ_RUN;
          end
        end
        default: begin
          nxt_st.state = PURSQ_HOLD;
          nxt_st.core_rst_n = 1'h0;
          nxt_st.wake_hold = 1'h0;
          nxt_st.abort = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= RESET_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Power-up timer on the RC oscillator
  pursq_edge_counter #(
    .COUNT(POWER_UP_TICKS),
    .WIDTH($clog2(POWER_UP_TICKS + 1))
  ) u_power_up_timer (
    .clk(CLK),
    .rst_n(rst_sync_ff),
    .start(st_ff.pu_start),
    .abort(st_ff.abort),
    .tick(rc_tick),
    .gate(1'h1),
    .busy(pu_busy),
    .done(pu_done)
  );

  // Oscillator start-up counter on main oscillator pulses
  pursq_edge_counter #(
    .COUNT(STARTUP_CYCLES),
    .WIDTH($clog2(STARTUP_CYCLES + 1))
  ) u_startup_counter (
    .clk(CLK),
    .rst_n(rst_sync_ff),
    .start(st_ff.su_start),
    .abort(st_ff.abort),
    .tick(osc_tick),
    .gate(st_ff.sync2[`PURSQ_SY_LVL]),
    .busy(su_busy),
    .done(su_done)
  );

  assign CORE_RESET_N = st_ff.core_rst_n;
  assign WAKE_HOLD = st_ff.wake_hold;
  assign POWER_UP_TIMER_BUSY = pu_busy;
  assign OSC_STARTUP_BUSY = su_busy;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_sync_ff);

  a_supply_low_hold:
    assert property (!st_ff.sync2[`PURSQ_SY_POR] |=> !CORE_RESET_N)
    else $error("core left reset while supply low");

  a_release_fall_resets:
    assert property ($fell(release_lvl) |=> !CORE_RESET_N ##1 (!POWER_UP_TIMER_BUSY && !OSC_STARTUP_BUSY))
    else $error("falling supply did not reset");

  a_start_both_together:
    assert property ((release_rise && st_ff.state == PURSQ_HOLD) |=> ##1 (POWER_UP_TIMER_BUSY && OSC_STARTUP_BUSY))
    else $error("counters did not start together");

  a_tied_por_start:
    assert property ((st_ff.sync2[`PURSQ_SY_TIED] && $rose(st_ff.sync2[`PURSQ_SY_POR])) |=> ##1 POWER_UP_TIMER_BUSY)
    else $error("tied pin start missing");

  a_pin_low_idle:
    assert property ((!st_ff.sync2[`PURSQ_SY_TIED] && !st_ff.sync2[`PURSQ_SY_PIN]) |=> ##1 !POWER_UP_TIMER_BUSY)
    else $error("timer ran with pin low");

  a_timer_holds_core:
    assert property (POWER_UP_TIMER_BUSY |-> !CORE_RESET_N)
    else $error("core out of reset while timer busy");

  a_release_after_both:
    assert property ($rose(CORE_RESET_N) |-> $past(pu_done) && $past(su_done))
    else $error("core released before both counters");

  a_level_gates_startup:
    assert property ((OSC_STARTUP_BUSY && !st_ff.sync2[`PURSQ_SY_LVL]) |=> !$rose(su_done))
    else $error("start-up counter finished below threshold");

  a_wake_slow_mode:
    assert property ((st_ff.state == PURSQ_RUN && release_lvl && WAKE_REQ && slow_start(OSC_MODE))
                     |=> WAKE_HOLD ##1 OSC_STARTUP_BUSY)
    else $error("slow mode wake skipped start-up delay");

  a_wake_fast_mode:
    assert property ((st_ff.state == PURSQ_RUN && WAKE_REQ && !slow_start(OSC_MODE)) |=> !WAKE_HOLD)
    else $error("fast mode wake was delayed");

endmodule : pursq_top

// ==== pursq_osc_model.sv ====
`timescale 1ns/1ps

module pursq_osc_model (
  // Clock
  input wire logic clk,
  // Control
  input wire logic run,
  input wire logic amp_ok,
  input wire logic [7:0] half,
  // Oscillator pins
  output logic osc,
  output logic level_ok
);
  logic [7:0] cnt = 8'h00;

  initial begin
    osc = 1'b0;
    level_ok = 1'b0;
  end

  // Crystal that swings only while powered, amplitude flagged separately
  always @(posedge clk) begin
    level_ok <= run & amp_ok;
    if (!run) begin
      cnt <= 8'h00;
      osc <= 1'b0;
    end else if (cnt >= half) begin
      cnt <= 8'h00;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : pursq_osc_model

// ==== testbench.sv ====
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic por = 1'b0;
  logic pin = 1'b0;
  logic tied = 1'b0;
  logic rc = 1'b0;
  logic rc_run = 1'b1;
  logic osc_run = 1'b0;
  logic amp_ok = 1'b0;
  logic [7:0] half = 8'h01;
  logic [1:0] mode = 2'h0;
  logic wake = 1'b0;
  logic [2:0] rc_div = 3'h0;
  logic osc;
  logic lvl;
  logic core_n;
  logic hold;
  logic pu_busy;
  logic su_busy;
  int cyc = 0;
  int ts;
  int tp;
  int to;
  int tr;
  int n_fail = 0;
  int check_count = 0;

  always #2 clk = ~clk;

  // RC oscillator, one rising edge every 16 clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rc_div <= rc_div + 3'h1;
    if (rc_run && rc_div == 3'h7) begin
      rc <= ~rc;
    end
  end

  pursq_osc_model i_osc (.clk(clk), .run(osc_run), .amp_ok(amp_ok), .half(half), .osc(osc), .level_ok(lvl));

  pursq_top #(.POWER_UP_TICKS(8), .STARTUP_CYCLES(4)) i_dut (
    .CLK(clk), .RESET_N(reset_n), .POR_DETECT(por), .MASTER_RESET_PIN(pin), .MRST_TIED(tied),
    .RC_OSC_IN(rc), .MAIN_OSC_IN(osc), .OSC_LEVEL_OK(lvl), .OSC_MODE(mode), .WAKE_REQ(wake),
    .CORE_RESET_N(core_n), .WAKE_HOLD(hold), .POWER_UP_TIMER_BUSY(pu_busy), .OSC_STARTUP_BUSY(su_busy));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Supply and crystal off, core must fall into reset
  task automatic power_off;
    step(1);
    por <= 1'b0;
    pin <= 1'b0;
    osc_run <= 1'b0;
    amp_ok <= 1'b0;
    step(10);
    #1;
    check(core_n, 1'b0);
    check({pu_busy, su_busy}, 2'b00);
    step(1);
  endtask : power_off

  // Watch a start-up until the core leaves reset
  task automatic await_release(input int limit, input bit fresh);
    ts = 0;
    tp = 0;
    to = 0;
    tr = 0;
    for (int i = 0; i < limit && tr == 0; i++) begin
      @(posedge clk);
      #1;
      if (ts == 0 && (pu_busy === 1'b1 || su_busy === 1'b1)) begin
        ts = cyc;
        if (fresh) check({pu_busy, su_busy}, 2'b11);
      end
      if (pu_busy === 1'b1) tp = cyc;
      if (su_busy === 1'b1) to = cyc;
      if (pu_busy === 1'b1 || su_busy === 1'b1) check(core_n, 1'b0);
      if (core_n === 1'b1) tr = cyc;
    end
    check((tr - (tp > to ? tp : to)) inside {[1:2]}, 1'b1);
  endtask : await_release

  task automatic sc_pin;
    power_off;
    tied <= 1'b0;
    half <= 8'h01;
    osc_run <= 1'b1;
    amp_ok <= 1'b1;
    por <= 1'b1;
    step(40);
    #1;
    check({core_n, pu_busy, su_busy}, 3'b000);
    step(1);
    pin <= 1'b1;
    await_release(400, 1'b1);
  endtask : sc_pin

  task automatic sc_tied_fast;
    power_off;
    tied <= 1'b1;
    osc_run <= 1'b1;
    amp_ok <= 1'b1;
    por <= 1'b1;
    await_release(400, 1'b1);
    check(tp > to, 1'b1);
    check((tp - ts) inside {[100:140]}, 1'b1);
  endtask : sc_tied_fast

  task automatic sc_slow_osc;
    power_off;
    half <= 8'h27;
    osc_run <= 1'b1;
    amp_ok <= 1'b1;
    por <= 1'b1;
    await_release(600, 1'b1);
    check(to > tp, 1'b1);
    check((to - ts) inside {[240:330]}, 1'b1);
  endtask : sc_slow_osc

  task automatic sc_threshold;
    power_off;
    half <= 8'h01;
    osc_run <= 1'b1;
    por <= 1'b1;
    step(300);
    #1;
    check({core_n, pu_busy, su_busy}, 3'b001);
    step(1);
    amp_ok <= 1'b1;
    await_release(100, 1'b0);
  endtask : sc_threshold

  task automatic sc_rc_stop;
    power_off;
    rc_run <= 1'b0;
    osc_run <= 1'b1;
    amp_ok <= 1'b1;
    por <= 1'b1;
    step(300);
    #1;
    check({core_n, pu_busy}, 2'b01);
    step(1);
    rc_run <= 1'b1;
    await_release(400, 1'b0);
  endtask : sc_rc_stop

  task automatic sc_wake;
    for (int m = 0; m < 4; m++) begin
      step(1);
      mode <= m[1:0];
      wake <= 1'b1;
      step(1);
      wake <= 1'b0;
      step(3);
      #1;
      check({hold, su_busy}, {2{m < 2}});
      check(core_n, 1'b1);
      for (int i = 0; i < 100 && hold !== 1'b0; i++) begin
        step(1);
        #1;
      end
      check(hold, 1'b0);
    end
  endtask : sc_wake

  initial begin
    step(10);
    reset_n <= 1'b1;
    sc_pin;
    sc_tied_fast;
    sc_slow_osc;
    sc_threshold;
    sc_rc_stop;
    sc_wake;
    wrap_up;
  end

  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
endmodule : testbench
